/* include/shift_test_pkg.sv */
package shift_test_pkg;

  // datapath geometry
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned PAIR_W  = 32;
  localparam int unsigned REG_NUM = 8;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned IMM_W   = 5;

  // effective count ceilings
  localparam logic [CNT_W-1:0] SINGLE_LL_MAX = 8'h11;
  localparam logic [CNT_W-1:0] PAIR_LL_MAX   = 8'h21;
  localparam logic [CNT_W-1:0] RIGHT_AR_MAX  = 8'h10;

  // values after reset
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_LEFT_LOGICAL_SINGLE,
    OP_LEFT_LOGICAL_PAIR,
    OP_LEFT_SHIFT_TEST_SINGLE,
    OP_LEFT_SHIFT_TEST_PAIR,
    OP_RIGHT_ARITH_SINGLE
  } shift_op_t;

  typedef struct packed {
    shift_op_t              op;
    logic [IDX_W-1:0]       operand_reg_field;
    logic [IDX_W-1:0]       count_reg_field;
    logic                   use_imm;
    logic [IMM_W-1:0]       imm_count;
  } shift_cmd_t;

  typedef struct packed {
    logic carry;
    logic overflow;
    logic even;
    logic negative;
    logic zero;
  } ind_t;

  localparam ind_t IND_RESET = '0;

  function automatic logic is_pair(input shift_op_t op);
    return (op == OP_LEFT_LOGICAL_PAIR) || (op == OP_LEFT_SHIFT_TEST_PAIR);
  endfunction

  function automatic logic is_test(input shift_op_t op);
    return (op == OP_LEFT_SHIFT_TEST_SINGLE) || (op == OP_LEFT_SHIFT_TEST_PAIR);
  endfunction

endpackage

/* design/ind_eval.sv */
`timescale 1ns/100ps
module ind_eval #(
  parameter int unsigned W = 16
) (
  // value under test
  input  wire logic [W-1:0] value_i,
  // result indicators
  output logic              even_o,
  output logic              negative_o,
  output logic              zero_o
);

  // even tests the low-order bit, negative the sign bit
  assign even_o     = ~value_i[0];
  assign negative_o = value_i[W-1];
  assign zero_o     = (value_i == '0);

endmodule // ind_eval

/* design/left_shift_test_unit.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - single left shift, immediate or low-byte register count
// - count register kept unless same as operand
// - single register count above 17 acts as 17
// - carry is last bit out; zero count clears
// - overflow cleared, set if sign ever changed
// - single shift indicators follow operand result
// - pair left shift, immediate or register count
// - named register is the high half
// - register seven pairs with register zero
// - zero count leaves pair unaltered
// - pair carry cleared, then last bit out
// - pair overflow cleared, set on sign change
// - pair register count above 33 acts as 33
// - count register kept unless inside the pair
// - pair indicators follow the whole 32 bits
// - test shift stops when a one leaves
// - early stop writes remaining count, low byte
// - coinciding registers end holding remaining count
// - test indicators follow the count register
// - pair test takes counts zero through 255
// - arithmetic right, clamp 16, carry/overflow kept
module left_shift_test_unit
  import shift_test_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // command from the decoder
  input  wire logic              start_i,
  input  wire shift_cmd_t        cmd_i,
  output logic                   ready_o,
  output logic                   done_o,
  // condition indicators
  output ind_t                   ind_o,
  // general register access
  input  wire logic              rf_wr_en_i,
  input  wire logic [IDX_W-1:0]  rf_wr_idx_i,
  input  wire logic [DATA_W-1:0] rf_wr_data_i,
  input  wire logic [IDX_W-1:0]  rf_rd_idx_i,
  output logic [DATA_W-1:0]      rf_rd_data_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_COMMIT
  } state_t;

  state_t            state_q;
  logic [DATA_W-1:0] regs_q [REG_NUM];
  logic [DATA_W-1:0] rd_data_q;
  shift_cmd_t        cmd_q;
  logic [PAIR_W-1:0] acc_q;
  logic [CNT_W-1:0]  cnt_left_q;
  logic [CNT_W-1:0]  cnt_init_q;
  logic              carry_w_q;
  logic              ovf_w_q;
  logic              early_q;
  logic              done_q;
  ind_t              ind_q;

  logic              accept;
  logic [IDX_W-1:0]  s_lo_idx;
  logic [CNT_W-1:0]  reg_cnt;
  logic [CNT_W-1:0]  raw_cnt;
  logic [CNT_W-1:0]  eff_cnt;
  logic [PAIR_W-1:0] load_val;

  logic [IDX_W-1:0]  r1_idx;
  logic [IDX_W-1:0]  lo_idx;
  logic [IDX_W-1:0]  r2_idx;
  logic              shifting;
  logic              out_bit;
  logic              r2_hit;
  logic [DATA_W-1:0] r2_base;
  logic [DATA_W-1:0] r2_final;
  logic [DATA_W-1:0] ind_val16;

  logic              ev16;
  logic              ng16;
  logic              zr16;
  logic              ev32;
  logic              ng32;
  logic              zr32;

  assign accept = start_i && (state_q == ST_IDLE);

  // start-time decode
  // pair index wraps
  assign s_lo_idx = IDX_W'(cmd_i.operand_reg_field + 3'h1);
  assign reg_cnt  = regs_q[cmd_i.count_reg_field][CNT_W-1:0];
  assign raw_cnt  = cmd_i.use_imm ? {3'h0, cmd_i.imm_count} : reg_cnt;

  always_comb begin
    case (cmd_i.op)
      OP_LEFT_LOGICAL_SINGLE: begin
        eff_cnt = (raw_cnt > SINGLE_LL_MAX) ? SINGLE_LL_MAX : raw_cnt;
      end
      OP_LEFT_LOGICAL_PAIR: begin
        eff_cnt = (raw_cnt > PAIR_LL_MAX) ? PAIR_LL_MAX : raw_cnt;
      end
      OP_LEFT_SHIFT_TEST_SINGLE,
      OP_LEFT_SHIFT_TEST_PAIR: begin
        eff_cnt = reg_cnt;
      end
      OP_RIGHT_ARITH_SINGLE: begin
        eff_cnt = ({3'h0, cmd_i.imm_count} > RIGHT_AR_MAX) ? RIGHT_AR_MAX : {3'h0, cmd_i.imm_count};
      end
      default: begin
        eff_cnt = CNT_RESET;
      end
    endcase
  end

  always_comb begin
    if (is_pair(cmd_i.op)) begin
      load_val = {regs_q[cmd_i.operand_reg_field], regs_q[s_lo_idx]};
    end else begin
      load_val = {regs_q[cmd_i.operand_reg_field], {DATA_W{1'b0}}};
    end
  end

  // working decode
  assign r1_idx   = cmd_q.operand_reg_field;
  assign lo_idx   = IDX_W'(cmd_q.operand_reg_field + 3'h1);
  assign r2_idx   = cmd_q.count_reg_field;
  assign shifting = (state_q == ST_SHIFT) && (cnt_left_q != CNT_RESET);
  assign out_bit  = acc_q[PAIR_W-1];

  // sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // early stop on a one out
          if (!shifting || (is_test(cmd_q.op) && out_bit)) begin
            state_q <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // command and count capture
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cmd_q      <= '0;
      cnt_init_q <= CNT_RESET;
    end else if (accept) begin
      cmd_q      <= cmd_i;
      cnt_init_q <= eff_cnt;
    end
  end

  // one bit per cycle shifter
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      acc_q      <= '0;
      cnt_left_q <= CNT_RESET;
      early_q    <= 1'b0;
    end else if (accept) begin
      acc_q      <= load_val;
      cnt_left_q <= eff_cnt;
      early_q    <= 1'b0;
    end else if (shifting) begin
      // the one that ends a test shift still leaves the top
      if (cmd_q.op == OP_RIGHT_ARITH_SINGLE) begin
        acc_q <= {acc_q[PAIR_W-1], acc_q[PAIR_W-1:1]};
      end else begin
        acc_q <= {acc_q[PAIR_W-2:0], 1'b0};
      end
      cnt_left_q <= cnt_left_q - 8'h01;
      // stop once a one has left
      if (is_test(cmd_q.op) && out_bit) begin
        early_q <= 1'b1;
      end
    end
  end

  // carry and overflow tracking
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      carry_w_q <= 1'b0;
      ovf_w_q   <= 1'b0;
    end else if (accept) begin
      carry_w_q <= 1'b0;
      ovf_w_q   <= 1'b0;
    end else if (shifting && cmd_q.op != OP_RIGHT_ARITH_SINGLE && !(is_test(cmd_q.op) && carry_w_q)) begin
      // last bit out of the top
      carry_w_q <= out_bit;
      if (acc_q[PAIR_W-1] != acc_q[PAIR_W-2]) begin
        ovf_w_q <= 1'b1;
      end
    end
  end

  // final count-source register value
  always_comb begin
    r2_hit = (r2_idx == r1_idx) || (is_pair(cmd_q.op) && r2_idx == lo_idx);
    if (r2_idx == r1_idx) begin
      r2_base = acc_q[PAIR_W-1:DATA_W];
    end else if (is_pair(cmd_q.op) && r2_idx == lo_idx) begin
      r2_base = acc_q[DATA_W-1:0];
    end else begin
      r2_base = regs_q[r2_idx];
    end
    // only the low byte takes the count
    if (early_q || r2_hit) begin
      r2_final = {r2_base[DATA_W-1:CNT_W], cnt_left_q};
    end else begin
      r2_final = r2_base;
    end
  end

  // test ops report the count register
  assign ind_val16 = is_test(cmd_q.op) ? r2_final : acc_q[PAIR_W-1:DATA_W];

  ind_eval #(
    .W (DATA_W)
  ) u_ind16 (
    .value_i    (ind_val16),
    .even_o     (ev16),
    .negative_o (ng16),
    .zero_o     (zr16)
  );

  ind_eval #(
    .W (PAIR_W)
  ) u_ind32 (
    .value_i    (acc_q),
    .even_o     (ev32),
    .negative_o (ng32),
    .zero_o     (zr32)
  );

  // indicator update at commit
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ind_q <= IND_RESET;
    end else if (state_q == ST_COMMIT) begin
      if (cmd_q.op != OP_RIGHT_ARITH_SINGLE) begin
        ind_q.carry    <= carry_w_q;
        ind_q.overflow <= ovf_w_q;
      end
      if (cmd_q.op == OP_LEFT_LOGICAL_PAIR) begin
        ind_q.even     <= ev32;
        ind_q.negative <= ng32;
        ind_q.zero     <= zr32;
      end else begin
        ind_q.even     <= ev16;
        ind_q.negative <= ng16;
        ind_q.zero     <= zr16;
      end
    end
  end

  // general registers: external writes only while idle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < REG_NUM; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (state_q == ST_IDLE && rf_wr_en_i) begin
      regs_q[rf_wr_idx_i] <= rf_wr_data_i;
    end else if (state_q == ST_COMMIT) begin
      // zero count writes back unchanged value
      regs_q[r1_idx] <= acc_q[PAIR_W-1:DATA_W];
      if (is_pair(cmd_q.op)) begin
        regs_q[lo_idx] <= acc_q[DATA_W-1:0];
      end
      if (is_test(cmd_q.op)) begin
        regs_q[r2_idx] <= r2_final;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rd_data_q <= REG_RESET;
      done_q    <= 1'b0;
    end else begin
      rd_data_q <= regs_q[rf_rd_idx_i];
      done_q    <= (state_q == ST_COMMIT);
    end
  end

  assign ready_o      = (state_q == ST_IDLE);
  assign done_o       = done_q;
  assign ind_o        = ind_q;
  assign rf_rd_data_o = rd_data_q;

  // checks
  sequence test_hit_s;
    state_q == ST_SHIFT && is_test(cmd_q.op) && cnt_left_q != CNT_RESET && acc_q[PAIR_W-1];
  endsequence

  sequence commit_done_s;
    state_q == ST_COMMIT ##1 done_o;
  endsequence

  single_clamp_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    accept && cmd_i.op == OP_LEFT_LOGICAL_SINGLE |=> cnt_left_q <= SINGLE_LL_MAX)
    else $error("single shift count exceeds 17");

  pair_clamp_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    accept && cmd_i.op == OP_LEFT_LOGICAL_PAIR |=> cnt_left_q <= PAIR_LL_MAX)
    else $error("pair shift count exceeds 33");

  arith_clamp_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    accept && cmd_i.op == OP_RIGHT_ARITH_SINGLE |=> cnt_left_q <= RIGHT_AR_MAX)
    else $error("arithmetic shift count exceeds 16");

  test_stop_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    test_hit_s |=> commit_done_s)
    else $error("test shift did not stop on a one");

  carry_out_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    shifting && cmd_q.op == OP_LEFT_LOGICAL_PAIR |=> carry_w_q == $past(acc_q[PAIR_W-1]))
    else $error("carry is not the last bit out");

  ovf_set_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    shifting && !is_test(cmd_q.op) && cmd_q.op != OP_RIGHT_ARITH_SINGLE
    && acc_q[PAIR_W-1] != acc_q[PAIR_W-2] |=> ovf_w_q)
    else $error("overflow missed a sign change");

  zero_carry_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    state_q == ST_COMMIT && cmd_q.op == OP_LEFT_LOGICAL_SINGLE && cnt_init_q == CNT_RESET
    |=> !ind_o.carry && !ind_o.overflow)
    else $error("zero count left carry set");

  pair_low_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    state_q == ST_COMMIT && cmd_q.op == OP_LEFT_LOGICAL_PAIR
    |=> regs_q[$past(lo_idx)] == $past(acc_q[DATA_W-1:0]))
    else $error("pair low half not written to next register");

  arith_keep_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    state_q == ST_COMMIT && cmd_q.op == OP_RIGHT_ARITH_SINGLE
    |=> $stable(ind_o.carry) && $stable(ind_o.overflow))
    else $error("arithmetic shift altered carry or overflow");

  remain_cnt_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    state_q == ST_COMMIT && is_test(cmd_q.op) && early_q
    |=> regs_q[$past(r2_idx)][CNT_W-1:0] == $past(cnt_left_q))
    else $error("remaining count not written");

  single_zero_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    state_q == ST_COMMIT && cmd_q.op == OP_LEFT_LOGICAL_SINGLE
    |=> ind_o.zero == (regs_q[$past(r1_idx)] == REG_RESET))
    else $error("zero indicator does not follow result");

  finish_in_time_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    accept |-> ##[3:259] done_o)
    else $error("command did not finish in time");

endmodule // left_shift_test_unit

/* verification/decoder_model.sv */
`timescale 1ns/100ps
module decoder_model
  import shift_test_pkg::*;
(
  // clock and handshake
  input  wire logic clk_sys_i,
  input  wire logic ready_i,
  // command to the unit
  output logic       start_o,
  output shift_cmd_t cmd_o
);
  initial begin
    start_o = 1'b0;
    cmd_o   = '0;
  end

  // request held until an edge sees ready
  task automatic issue(input shift_cmd_t c);
    @(negedge clk_sys_i);
    start_o = 1'b1;
    cmd_o   = c;
    while (ready_i !== 1'b1) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    start_o = 1'b0;
    cmd_o   = shift_cmd_t'(~c);
  endtask
endmodule // decoder_model

/* verification/left_shift_and_test_unit_test.sv */
`timescale 1ns/100ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("wrong value at %0t: %s", $time, m); end end
module left_shift_and_test_unit_test
  import shift_test_pkg::*;
;
  typedef struct {
    shift_cmd_t  c;
    logic [15:0] a;
    logic [15:0] b;
  } case_t;
  logic              clk_sys_i;
  logic              resetn_i;
  logic              start_i;
  shift_cmd_t        cmd_i;
  logic              ready_o;
  logic              done_o;
  ind_t              ind_o;
  logic              rf_wr_en_i;
  logic [IDX_W-1:0]  rf_wr_idx_i;
  logic [DATA_W-1:0] rf_wr_data_i;
  logic [IDX_W-1:0]  rf_rd_idx_i;
  logic [DATA_W-1:0] rf_rd_data_o;
  logic [15:0]       m_reg [8];
  ind_t              m_ind;
  ind_t              exp_q [$];
  int                mismatches = 0;
  int                check_count = 0;
  case_t             cases [12] = '{
    '{'{OP_LEFT_LOGICAL_SINGLE, 3'd1, 3'd2, 1'b0, 5'd0}, 16'h4001, 16'h0000},
    '{'{OP_LEFT_LOGICAL_SINGLE, 3'd1, 3'd2, 1'b0, 5'd0}, 16'h8003, 16'h00ff},
    '{'{OP_LEFT_LOGICAL_SINGLE, 3'd3, 3'd3, 1'b0, 5'd0}, 16'h0005, 16'h0003},
    '{'{OP_LEFT_LOGICAL_SINGLE, 3'd2, 3'd6, 1'b1, 5'd5}, 16'h0c01, 16'h0000},
    '{'{OP_LEFT_LOGICAL_PAIR, 3'd7, 3'd3, 1'b1, 5'd20}, 16'h1234, 16'h00ff},
    '{'{OP_LEFT_LOGICAL_PAIR, 3'd4, 3'd5, 1'b0, 5'd0}, 16'h0f0f, 16'h0021},
    '{'{OP_LEFT_LOGICAL_PAIR, 3'd2, 3'd6, 1'b0, 5'd0}, 16'h0001, 16'h00c8},
    '{'{OP_LEFT_LOGICAL_PAIR, 3'd0, 3'd6, 1'b0, 5'd0}, 16'hc001, 16'h0000},
    '{'{OP_LEFT_SHIFT_TEST_SINGLE, 3'd1, 3'd2, 1'b0, 5'd0}, 16'h0100, 16'h0009},
    '{'{OP_LEFT_SHIFT_TEST_SINGLE, 3'd3, 3'd3, 1'b0, 5'd0}, 16'h0000, 16'h0005},
    '{'{OP_LEFT_SHIFT_TEST_PAIR, 3'd7, 3'd0, 1'b0, 5'd0}, 16'h0002, 16'h0010},
    '{'{OP_RIGHT_ARITH_SINGLE, 3'd6, 3'd1, 1'b1, 5'd31}, 16'h8421, 16'h0000}
  };

  decoder_model dec (
    .clk_sys_i (clk_sys_i),
    .ready_i   (ready_o),
    .start_o   (start_i),
    .cmd_o     (cmd_i)
  );

  left_shift_test_unit dut (
    .clk_sys_i    (clk_sys_i),
    .resetn_i     (resetn_i),
    .start_i      (start_i),
    .cmd_i        (cmd_i),
    .ready_o      (ready_o),
    .done_o       (done_o),
    .ind_o        (ind_o),
    .rf_wr_en_i   (rf_wr_en_i),
    .rf_wr_idx_i  (rf_wr_idx_i),
    .rf_wr_data_i (rf_wr_data_i),
    .rf_rd_idx_i  (rf_rd_idx_i),
    .rf_rd_data_o (rf_rd_data_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // bit-serial reference of one command
  task automatic predict(input shift_cmd_t c);
    logic [31:0] v;
    logic [2:0]  r, lo, cs;
    logic        b, tst, pr, early;
    int          n, w, rem, nw;
    r = c.operand_reg_field;
    lo = r + 3'd1;
    cs = c.count_reg_field;
    pr = (c.op == OP_LEFT_LOGICAL_PAIR) || (c.op == OP_LEFT_SHIFT_TEST_PAIR);
    tst = (c.op == OP_LEFT_SHIFT_TEST_SINGLE) || (c.op == OP_LEFT_SHIFT_TEST_PAIR);
    w = pr ? 32 : 16;
    n = (c.use_imm && !tst) ? c.imm_count : m_reg[cs][7:0];
    v = pr ? {m_reg[r], m_reg[lo]} : {16'h0000, m_reg[r]};
    if (c.op == OP_RIGHT_ARITH_SINGLE) begin
      n = (c.imm_count > 16) ? 16 : c.imm_count;
      m_reg[r] = $signed(v[15:0]) >>> n;
    end else begin
      if (!tst) n = (n > w + 1) ? w + 1 : n;
      m_ind.carry = 1'b0;
      m_ind.overflow = 1'b0;
      early = 1'b0;
      rem = n;
      while (rem > 0 && !early) begin
        b = v[w-1];
        v = v << 1;
        rem--;
        m_ind.carry = b;
        if (v[w-1] != b) m_ind.overflow = 1'b1;
        early = tst && b;
      end
      if (pr) {m_reg[r], m_reg[lo]} = v;
      else m_reg[r] = v[15:0];
      if (tst && (early || cs == r || (pr && cs == lo))) m_reg[cs][7:0] = rem[7:0];
    end
    nw = (pr && !tst) ? 32 : 16;
    v = tst ? {16'h0000, m_reg[cs]} : (pr ? {m_reg[r], m_reg[lo]} : {16'h0000, m_reg[r]});
    m_ind.even = ~v[0];
    m_ind.negative = v[nw-1];
    m_ind.zero = (v == 32'h0000_0000);
  endtask

  task automatic wr(input logic [2:0] i, input logic [15:0] d, input bit upd);
    @(negedge clk_sys_i);
    rf_wr_en_i = 1'b1;
    rf_wr_idx_i = i;
    rf_wr_data_i = d;
    @(negedge clk_sys_i);
    rf_wr_en_i = 1'b0;
    if (upd) m_reg[i] = d;
  endtask

  task automatic read_all();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys_i);
      rf_rd_idx_i = i[2:0];
      @(negedge clk_sys_i);
      `CHK(rf_rd_data_o, m_reg[i], "register contents")
    end
  endtask

  task automatic run(input case_t t, input bit busy_wr);
    int k;
    wr(t.c.operand_reg_field + 3'd1, t.a ^ 16'h5a3c, 1'b1);
    wr(t.c.operand_reg_field, t.a, 1'b1);
    wr(t.c.count_reg_field, t.b, 1'b1);
    predict(t.c);
    exp_q.push_back(m_ind);
    dec.issue(t.c);
    // write while busy must be ignored
    if (busy_wr) wr(3'd4, 16'hbeef, 1'b0);
    k = 0;
    while (done_o !== 1'b1 && k < 300) begin
      @(negedge clk_sys_i);
      k++;
    end
    `CHK(done_o, 1'b1, "no completion")
    read_all();
  endtask

  // result watcher
  always @(negedge clk_sys_i) begin
    if (resetn_i === 1'b1 && done_o === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1, "unexpected completion")
      if (exp_q.size() > 0) begin
        `CHK(ind_o, exp_q.pop_front(), "indicators")
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk_sys_i);
    mismatches++;
    $display("wrong value at %0t: run timed out", $time);
    conclude();
  end

  initial begin
    case_t t;
    resetn_i = 1'b0;
    rf_wr_en_i = 1'b0;
    rf_wr_idx_i = '0;
    rf_wr_data_i = '0;
    rf_rd_idx_i = '0;
    m_ind = IND_RESET;
    for (int i = 0; i < 8; i++) m_reg[i] = 16'h0000;
    void'($urandom(32'hd974));
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    `CHK(ready_o, 1'b1, "idle after reset")
    `CHK(done_o, 1'b0, "done after reset")
    `CHK(ind_o, IND_RESET, "indicators after reset")
    read_all();
    $display("test reset done");
    foreach (cases[i]) run(cases[i], i == 1);
    $display("test directed done");
    repeat (28) begin
      t.c.op = shift_op_t'(3'($urandom_range(0, 4)));
      t.c.operand_reg_field = 3'($urandom);
      t.c.count_reg_field = 3'($urandom);
      t.c.use_imm = 1'($urandom);
      t.c.imm_count = 5'($urandom);
      t.a = 16'($urandom);
      t.b = 16'($urandom);
      if (t.c.op == OP_LEFT_SHIFT_TEST_SINGLE || t.c.op == OP_LEFT_SHIFT_TEST_PAIR) t.b[15:8] = 8'h00;
      run(t, 1'b0);
    end
    $display("test random done");
    conclude();
  end
endmodule // left_shift_and_test_unit_test
